// ===== sci_regs.svh
// Register offsets, field positions, reset values and link counts for the serial
// configuration path. Included by the package; assumes nothing else is defined.
//
// Overview of operation
// (RULE1) Frame check is on after reset
// (RULE2) Clearing check-enable bit turns frame check off
// (RULE3) The disabling write itself still carries check byte
// (RULE4) Disable frame is bytes 02 00 26 24
// (RULE5) Serial output stays off after reset
// (RULE6) All read data leaves through serial output
// (RULE7) Clearing output-disable bit turns serial output on
// (RULE8) Host powers converter buffer before using converter
// (RULE9) Unchecked mode takes three-byte frames, same decode
`ifndef SCI_REGS_SVH
`define SCI_REGS_SVH

// Register addresses (7-bit)
`define SCI_ADDR_CONFIG      7'h02
`define SCI_ADDR_STATUS      7'h03
`define SCI_ADDR_CONV_CFG    7'h10
`define SCI_ADDR_CONV_RES    7'h11

// General configuration fields
`define SCI_CFG_CRC_EN_BIT   0
`define SCI_CFG_SDO_DIS_BIT  1
`define SCI_CFG_RESET        16'h0027

// Converter setup fields
`define SCI_CONV_CONVERTER_BUFFER_POWERDOWN_BIT  0
`define SCI_CONV_CFG_RESET   16'h0001

// Status fields
`define SCI_STAT_CRC_ERR_BIT 0

// Frame check code
`define SCI_CRC_POLY         8'h07
`define SCI_CRC_INIT         8'h00

// Frame layout in bits
`define SCI_ADDR_BITS        6'd8
`define SCI_CMD_BITS         6'd24
`define SCI_FRAME_BITS_CRC   6'd32
`define SCI_CNT_MAX          6'h3f

// Serial clock half period in system clock cycles
`define SCI_SCLK_HALF        4

`endif

// ===== sci_pkg.sv
// Types shared by both ends of the serial configuration link.
// Assumes sci_regs.svh is on the include path.
`include "sci_regs.svh"

package sci_pkg;

    typedef enum logic [1:0] {
        SCI_H_IDLE  = 2'b00,
        SCI_H_SHIFT = 2'b01,
        SCI_H_DONE  = 2'b10,
        SCI_H_GAP   = 2'b11
    } sci_hstate_e;

    typedef struct packed {
        logic        sclk_q;
        logic        cs_n_q;
        logic [5:0]  cnt;
        logic [23:0] sh;
        logic [7:0]  crc;
        logic [7:0]  chk;
        logic [15:0] out_sr;
        logic        miso;
        logic [15:0] cfg;
        logic [15:0] conv;
        logic        crc_err;
        logic        err_pulse;
        logic        wr_pulse;
    } sci_dev_s;

    typedef struct packed {
        sci_hstate_e st;
        logic [7:0]  div;
        logic        sclk;
        logic        cs_n;
        logic        mosi;
        logic [5:0]  cnt;
        logic [5:0]  nbits;
        logic [31:0] tx;
        logic [15:0] rx;
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] data;
        logic        crc_on;
        logic        sdo_on;
        logic        buf_on;
        logic        rsp_valid;
        logic        rsp_err;
        logic [15:0] rsp_data;
    } sci_host_s;

    // One step of the frame check code, most significant bit first
    function automatic logic [7:0] sci_crc_bit(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        return {c[6:0], 1'b0} ^ (fb ? `SCI_CRC_POLY : 8'h00);
    endfunction : sci_crc_bit

endpackage : sci_pkg

// ===== sci_link_if.sv
// Four-wire serial link between host and device.
// Serial data output has a pull-up: it reads high when nobody drives it.
`timescale 1ns/1ns
`default_nettype none

interface sci_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev  (input cs_n, sclk, mosi, output miso, miso_oe);
    modport host (output cs_n, sclk, mosi, input miso_line);
endinterface : sci_link_if

`default_nettype wire

// ===== sci_dev.sv
// Device end of the serial configuration link: frame receiver, frame check,
// configuration registers and serial read-back.
// Assumes link pins synchronous to i_clk_sys and a host clock at most a quarter rate.
`timescale 1ns/1ns
`default_nettype none

`include "sci_regs.svh"

module sci_dev
    import sci_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // Link
    sci_link_if.dev          link,
    // Converter result to read back
    input  wire logic [15:0] i_conv_result,
    // Configuration state
    output logic             o_crc_en,
    output logic             o_sdo_en,
    output logic             o_conv_buf_on,
    output logic [15:0]      o_cfg,
    output logic [15:0]      o_conv_cfg,
    // Events and sticky check-error flag
    output logic             o_crc_err,
    output logic             o_frame_err,
    output logic             o_wr_strobe
);

    sci_dev_s r_r;
    sci_dev_s r_nxt;

    logic       rise;
    logic       fall;
    logic       frame_end;
    logic [6:0] rd_addr;
    logic       rd_flag;
    logic [6:0] wr_addr;
    logic       wr_cmd;
    logic       len_ok;
    logic       chk_ok;
    logic       exec;

    always_comb begin
        rise      = link.sclk & ~r_r.sclk_q & ~link.cs_n;
        fall      = ~link.sclk & r_r.sclk_q & ~link.cs_n;
        frame_end = link.cs_n & ~r_r.cs_n_q;
        rd_addr   = {r_r.sh[5:0], link.mosi};
        rd_flag   = r_r.sh[6];
        wr_addr   = r_r.sh[22:16];
        wr_cmd    = ~r_r.sh[23];
        chk_ok    = (r_r.crc == r_r.chk);
        if (r_r.cfg[`SCI_CFG_CRC_EN_BIT]) begin
            // Checked frames need all four bytes and a matching check byte
            len_ok = (r_r.cnt == `SCI_FRAME_BITS_CRC) & chk_ok;    // [RULE1] [RULE3]
        end else begin
            // Unchecked frames are exactly the three command bytes
            len_ok = (r_r.cnt == `SCI_CMD_BITS);                   // [RULE9]
        end
        exec = frame_end & len_ok & wr_cmd;
    end

    always_comb begin
        r_nxt           = r_r;
        r_nxt.sclk_q    = link.sclk;
        r_nxt.cs_n_q    = link.cs_n;
        r_nxt.err_pulse = 1'b0;
        r_nxt.wr_pulse  = 1'b0;

        // Bit capture on rising serial clock
        if (rise) begin
            if (r_r.cnt < `SCI_CMD_BITS) begin
                r_nxt.sh  = {r_r.sh[22:0], link.mosi};
                r_nxt.crc = sci_crc_bit(r_r.crc, link.mosi);
            end else if (r_r.cnt < `SCI_FRAME_BITS_CRC) begin
                r_nxt.chk = {r_r.chk[6:0], link.mosi};
            end
            if (r_r.cnt != `SCI_CNT_MAX) begin
                r_nxt.cnt = r_r.cnt + 6'd1;
            end
            // Address byte complete: fetch read-back word
            if (r_r.cnt == `SCI_ADDR_BITS - 6'd1 && rd_flag) begin
                case (rd_addr)
                    `SCI_ADDR_CONFIG:   r_nxt.out_sr = r_r.cfg;
                    `SCI_ADDR_CONV_CFG: r_nxt.out_sr = r_r.conv;
                    `SCI_ADDR_CONV_RES: r_nxt.out_sr = i_conv_result;  // [RULE6]
                    `SCI_ADDR_STATUS: begin
                        r_nxt.out_sr = 16'h0000;
                        r_nxt.out_sr[`SCI_STAT_CRC_ERR_BIT] = r_r.crc_err;
                        r_nxt.crc_err = 1'b0;
                    end
                    default:            r_nxt.out_sr = 16'h0000;
                endcase
            end
        end

        // Read-back bits change on falling serial clock
        if (fall && r_r.cnt >= `SCI_ADDR_BITS && r_r.cnt < `SCI_CMD_BITS) begin
            r_nxt.miso   = r_r.out_sr[15];                         // [RULE6]
            r_nxt.out_sr = {r_r.out_sr[14:0], 1'b0};
        end

        // Frame end: decode and execute
        if (frame_end) begin
            if (exec) begin
                r_nxt.wr_pulse = 1'b1;
                case (wr_addr)
                    `SCI_ADDR_CONFIG:   r_nxt.cfg  = r_r.sh[15:0];  // [RULE2] [RULE7]
                    `SCI_ADDR_CONV_CFG: r_nxt.conv = r_r.sh[15:0];
                    default:            r_nxt.wr_pulse = 1'b0;
                endcase
            end
            if (r_r.cnt != 6'd0 && !len_ok) begin
                r_nxt.err_pulse = 1'b1;
                // Set wins over a clear in the same cycle
                r_nxt.crc_err   = 1'b1;
            end
            r_nxt.cnt  = 6'd0;
            r_nxt.crc  = `SCI_CRC_INIT;
            r_nxt.chk  = 8'h00;
            r_nxt.sh   = 24'h000000;
            r_nxt.miso = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_r.sclk_q    <= 1'b0;
            r_r.cs_n_q    <= 1'b1;
            r_r.cnt       <= 6'd0;
            r_r.sh        <= 24'h000000;
            r_r.crc       <= `SCI_CRC_INIT;
            r_r.chk       <= 8'h00;
            r_r.out_sr    <= 16'h0000;
            r_r.miso      <= 1'b0;
            r_r.cfg       <= `SCI_CFG_RESET;                       // [RULE1] [RULE5]
            r_r.conv      <= `SCI_CONV_CFG_RESET;
            r_r.crc_err   <= 1'b0;
            r_r.err_pulse <= 1'b0;
            r_r.wr_pulse  <= 1'b0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Output driver only while selected and enabled
    assign link.miso    = r_r.miso;
    assign link.miso_oe = ~link.cs_n & ~r_r.cfg[`SCI_CFG_SDO_DIS_BIT];  // [RULE5] [RULE7]

    assign o_crc_en      = r_r.cfg[`SCI_CFG_CRC_EN_BIT];
    assign o_sdo_en      = ~r_r.cfg[`SCI_CFG_SDO_DIS_BIT];
    assign o_conv_buf_on = ~r_r.conv[`SCI_CONV_CONVERTER_BUFFER_POWERDOWN_BIT];
    assign o_cfg         = r_r.cfg;
    assign o_conv_cfg    = r_r.conv;
    assign o_crc_err     = r_r.crc_err;
    assign o_frame_err   = r_r.err_pulse;
    assign o_wr_strobe   = r_r.wr_pulse;

endmodule : sci_dev

`default_nettype wire

// ===== sci_host.sv
// Host end of the serial configuration link: turns register commands into
// frames, appends the check byte while checking is on, and tracks device setup.
// Assumes the device follows sci_regs.svh and has just come out of reset.
`timescale 1ns/1ns
`default_nettype none

`include "sci_regs.svh"

module sci_host
    import sci_pkg::*;
#(
    parameter int HALF = `SCI_SCLK_HALF
)(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // Link
    sci_link_if.host         link,
    // Command
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire logic        i_cmd_read,
    input  wire logic [6:0]  i_cmd_addr,
    input  wire logic [15:0] i_cmd_data,
    // Response
    output logic             o_rsp_valid,
    output logic             o_rsp_err,
    output logic [15:0]      o_rsp_data,
    // Tracked device setup
    output logic             o_crc_on,
    output logic             o_sdo_on,
    output logic             o_buf_on
);

    sci_host_s r_r;
    sci_host_s r_nxt;

    logic        tick;
    logic [7:0]  crc;
    logic [23:0] cmd;
    logic        refuse;

    always_comb begin
        tick = (r_r.div == 8'(HALF - 1));
        cmd  = {i_cmd_read, i_cmd_addr, (i_cmd_read ? 16'h0000 : i_cmd_data)};
        crc  = `SCI_CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            crc = sci_crc_bit(crc, cmd[i]);                        // [RULE3] [RULE4]
        end
        // No read without serial output; no result before buffer power
        refuse = i_cmd_read & (~r_r.sdo_on |                       // [RULE6]
                 (i_cmd_addr == `SCI_ADDR_CONV_RES & ~r_r.buf_on)); // [RULE8]
        o_cmd_ready = (r_r.st == SCI_H_IDLE);
    end

    always_comb begin
        r_nxt           = r_r;
        r_nxt.rsp_valid = 1'b0;
        r_nxt.div       = (tick || r_r.st == SCI_H_IDLE) ? 8'h00 : r_r.div + 8'h01;
        case (r_r.st)
            SCI_H_IDLE: begin
                if (i_cmd_valid) begin
                    if (refuse) begin
                        r_nxt.rsp_valid = 1'b1;
                        r_nxt.rsp_err   = 1'b1;
                        r_nxt.rsp_data  = 16'h0000;
                    end else begin
                        r_nxt.tx    = {cmd, crc};
                        r_nxt.nbits = r_r.crc_on ? `SCI_FRAME_BITS_CRC : `SCI_CMD_BITS;  // [RULE9]
                        r_nxt.rd    = i_cmd_read;
                        r_nxt.addr  = i_cmd_addr;
                        r_nxt.data  = i_cmd_data;
                        r_nxt.cnt   = 6'd0;
                        r_nxt.cs_n  = 1'b0;
                        r_nxt.mosi  = cmd[23];
                        r_nxt.st    = SCI_H_SHIFT;
                    end
                end
            end
            SCI_H_SHIFT: begin
                if (tick) begin
                    if (!r_r.sclk) begin
                        r_nxt.sclk = 1'b1;
                        if (r_r.cnt >= `SCI_ADDR_BITS && r_r.cnt < `SCI_CMD_BITS) begin
                            r_nxt.rx = {r_r.rx[14:0], link.miso_line};
                        end
                    end else begin
                        r_nxt.sclk = 1'b0;
                        r_nxt.cnt  = r_r.cnt + 6'd1;
                        r_nxt.tx   = {r_r.tx[30:0], 1'b0};
                        r_nxt.mosi = r_r.tx[30];
                        if (r_r.cnt + 6'd1 == r_r.nbits) begin
                            r_nxt.st = SCI_H_DONE;
                        end
                    end
                end
            end
            SCI_H_DONE: begin
                if (tick) begin
                    r_nxt.cs_n      = 1'b1;
                    r_nxt.mosi      = 1'b0;
                    r_nxt.rsp_valid = 1'b1;
                    r_nxt.rsp_err   = 1'b0;
                    r_nxt.rsp_data  = r_r.rd ? r_r.rx : 16'h0000;
                    if (!r_r.rd && r_r.addr == `SCI_ADDR_CONFIG) begin
                        r_nxt.crc_on = r_r.data[`SCI_CFG_CRC_EN_BIT];   // [RULE2]
                        r_nxt.sdo_on = ~r_r.data[`SCI_CFG_SDO_DIS_BIT]; // [RULE7]
                    end
                    if (!r_r.rd && r_r.addr == `SCI_ADDR_CONV_CFG) begin
                        r_nxt.buf_on = ~r_r.data[`SCI_CONV_CONVERTER_BUFFER_POWERDOWN_BIT]; // [RULE8]
                    end
                    r_nxt.st = SCI_H_GAP;
                end
            end
            SCI_H_GAP: begin
                if (tick) begin
                    r_nxt.st = SCI_H_IDLE;
                end
            end
            default: r_nxt.st = SCI_H_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_r.st        <= SCI_H_IDLE;
            r_r.div       <= 8'h00;
            r_r.sclk      <= 1'b0;
            r_r.cs_n      <= 1'b1;
            r_r.mosi      <= 1'b0;
            r_r.cnt       <= 6'd0;
            r_r.nbits     <= `SCI_FRAME_BITS_CRC;
            r_r.tx        <= 32'h00000000;
            r_r.rx        <= 16'h0000;
            r_r.rd        <= 1'b0;
            r_r.addr      <= 7'h00;
            r_r.data      <= 16'h0000;
            r_r.crc_on    <= 1'b1;                                  // [RULE1]
            r_r.sdo_on    <= 1'b0;
            r_r.buf_on    <= 1'b0;
            r_r.rsp_valid <= 1'b0;
            r_r.rsp_err   <= 1'b0;
            r_r.rsp_data  <= 16'h0000;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign link.cs_n   = r_r.cs_n;
    assign link.sclk   = r_r.sclk;
    assign link.mosi   = r_r.mosi;
    assign o_rsp_valid = r_r.rsp_valid;
    assign o_rsp_err   = r_r.rsp_err;
    assign o_rsp_data  = r_r.rsp_data;
    assign o_crc_on    = r_r.crc_on;
    assign o_sdo_on    = r_r.sdo_on;
    assign o_buf_on    = r_r.buf_on;

endmodule : sci_host

`default_nettype wire

// ===== sci_link_properties.sv
// Wire-level checks of the serial configuration link between host and device.
// Assumes HALF >= 2 and that only well-formed frames are sent by the host.
`timescale 1ns/1ns
`default_nettype none

module sci_link_properties (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_line
);
    logic        sclk_q_r;
    logic        cs_q_r;
    logic [5:0]  bits_r;
    logic [31:0] sh_r;
    logic        crc_off_r;
    logic        sdo_on_r;
    logic [23:0] cmd;

    // Command part of the frame just closed
    assign cmd = (bits_r == 6'd32) ? sh_r[31:8] : sh_r[23:0];

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_q_r  <= 1'b0;
            cs_q_r    <= 1'b1;
            bits_r    <= 6'd0;
            sh_r      <= 32'h0;
            crc_off_r <= 1'b0;
            sdo_on_r  <= 1'b0;
        end else begin
            sclk_q_r <= sclk;
            cs_q_r   <= cs_n;
            if (!cs_n && sclk && !sclk_q_r) begin
                bits_r <= bits_r + 6'd1;
                sh_r   <= {sh_r[30:0], mosi};
            end
            if (cs_n && !cs_q_r) begin
                bits_r <= 6'd0;
                if (cmd[23:16] == 8'h02) begin
                    crc_off_r <= ~cmd[0];
                    sdo_on_r  <= ~cmd[1];
                end
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_idle_no_drive: assert property (cs_n || !sdo_on_r |-> !miso_oe)
        else $error("serial output driven while off or deselected");
    a_oe_tracks_cfg: assert property (!cs_n && !$past(cs_n) |-> miso_oe == sdo_on_r)
        else $error("serial output enable differs from written setting");
    a_frame_len: assert property (cs_n && !cs_q_r |-> bits_r == (crc_off_r ? 6'd24 : 6'd32))
        else $error("frame length does not match check mode");
    a_len_bounded: assert property (!cs_n |-> bits_r <= 6'd32)
        else $error("frame longer than a checked frame");
    a_disable_byte: assert property (cs_n && !cs_q_r && bits_r == 6'd32 && sh_r[31:8] == 24'h020026
        |-> sh_r[7:0] == 8'h24)
        else $error("check-off frame carries a wrong check byte");
    a_read_needs_out: assert property (cs_n && !cs_q_r && bits_r != 6'd0 && cmd[23] |-> sdo_on_r)
        else $error("read frame sent while serial output is off");
    a_sclk_idle_low: assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("serial clock moves between frames");
    a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*3])
        else $error("frames too close together");

endmodule : sci_link_properties

`default_nettype wire

// ===== test_serial_config_init.sv
// Self-checking bench: host and device joined by the link interface.
// Assumes HALF = 2 and the register layout of sci_regs.svh.
`timescale 1ns/1ns
`default_nettype none

module test_serial_config_init;
    typedef struct packed {
        logic        err;
        logic [15:0] data;
    } sci_exp_s;

    logic        i_clk_sys, i_rst_n, cmd_valid, cmd_read, cmd_ready, rsp_valid, rsp_err;
    logic        crc_en, sdo_en, cbuf_on, crc_err, crc_on, sdo_on, buf_on, wr_strobe, frame_err;
    logic [6:0]  cmd_addr;
    logic [15:0] cmd_data, conv_result, cfg, conv_cfg, rsp_data;
    logic [31:0] lfsr_r;
    sci_exp_s    exp_q[$];
    sci_exp_s    exp_now;
    int          num_errors, n_checks, n_wr, n_ferr, i;

    sci_link_if i_sci_link_if();

    sci_dev i_sci_dev (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .link(i_sci_link_if),
        .i_conv_result(conv_result), .o_crc_en(crc_en), .o_sdo_en(sdo_en), .o_conv_buf_on(cbuf_on),
        .o_cfg(cfg), .o_conv_cfg(conv_cfg), .o_crc_err(crc_err), .o_frame_err(frame_err),
        .o_wr_strobe(wr_strobe));

    sci_host #(.HALF(2)) i_sci_host (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .link(i_sci_link_if),
        .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read), .i_cmd_addr(cmd_addr),
        .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid), .o_rsp_err(rsp_err), .o_rsp_data(rsp_data),
        .o_crc_on(crc_on), .o_sdo_on(sdo_on), .o_buf_on(buf_on));

    sci_link_properties i_sci_link_properties (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .cs_n(i_sci_link_if.cs_n), .sclk(i_sci_link_if.sclk), .mosi(i_sci_link_if.mosi),
        .miso(i_sci_link_if.miso), .miso_oe(i_sci_link_if.miso_oe), .miso_line(i_sci_link_if.miso_line));

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr_next

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // One command; expected response queued for the monitor
    task automatic do_cmd(input logic rd, input logic [6:0] a, input logic [15:0] d,
                          input logic e, input logic [15:0] x);
        int n;
        exp_q.push_back({e, x});
        @(posedge i_clk_sys);
        cmd_valid <= 1'b1;
        cmd_read  <= rd;
        cmd_addr  <= a;
        cmd_data  <= d;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 100);
        cmd_valid <= 1'b0;
        for (n = 0; n < 3000 && (exp_q.size() != 0 || cmd_ready !== 1'b1); n++)
            @(posedge i_clk_sys);
    endtask : do_cmd

    task automatic chk_state(input logic c, input logic s, input logic b);
        @(negedge i_clk_sys);
        check("crc_en", crc_en, c);
        check("crc_on", crc_on, c);
        check("sdo_en", sdo_en, s);
        check("sdo_on", sdo_on, s);
        check("cbuf_on", cbuf_on, b);
        check("buf_on", buf_on, b);
    endtask : chk_state

    always @(posedge i_clk_sys) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("rsp_extra", 16'h1, 16'h0);
            end else begin
                exp_now = exp_q.pop_front();
                check("rsp_err", rsp_err, exp_now.err);
                check("rsp_data", rsp_data, exp_now.data);
            end
        end
        if (wr_strobe === 1'b1)
            n_wr++;
        if (frame_err === 1'b1)
            n_ferr++;
    end

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        num_errors++;
        $display("ERROR watchdog expected done seen timeout");
        summarize();
    end

    initial begin
        i_rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_addr = 7'h00;
        cmd_data = 16'h0000;
        conv_result = 16'h0000;
        lfsr_r = 32'h8cc67369;
        repeat (5) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        chk_state(1'b1, 1'b0, 1'b0);
        check("cfg", cfg, 16'h0027);
        check("conv_cfg", conv_cfg, 16'h0001);
        $display("test reset done");
        do_cmd(1'b1, 7'h02, 16'h0000, 1'b1, 16'h0000);
        do_cmd(1'b1, 7'h11, 16'h0000, 1'b1, 16'h0000);
        $display("test refused reads done");
        do_cmd(1'b0, 7'h02, 16'h0026, 1'b0, 16'h0000);
        chk_state(1'b0, 1'b0, 1'b0);
        check("cfg", cfg, 16'h0026);
        $display("test check off done");
        do_cmd(1'b0, 7'h02, 16'h0024, 1'b0, 16'h0000);
        chk_state(1'b0, 1'b1, 1'b0);
        do_cmd(1'b1, 7'h02, 16'h0000, 1'b0, 16'h0024);
        do_cmd(1'b1, 7'h55, 16'h0000, 1'b0, 16'h0000);
        do_cmd(1'b1, 7'h03, 16'h0000, 1'b0, 16'h0000);
        do_cmd(1'b1, 7'h11, 16'h0000, 1'b1, 16'h0000);
        $display("test output on done");
        do_cmd(1'b0, 7'h10, 16'h0000, 1'b0, 16'h0000);
        chk_state(1'b0, 1'b1, 1'b1);
        check("conv_cfg", conv_cfg, 16'h0000);
        for (i = 0; i < 6; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            @(posedge i_clk_sys);
            conv_result <= lfsr_r[15:0];
            do_cmd(1'b1, 7'h11, 16'h0000, 1'b0, lfsr_r[15:0]);
        end
        $display("test converter reads done");
        // Second power-up in mid-run: defaults return, disable frame works again
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        chk_state(1'b1, 1'b0, 1'b0);
        check("cfg", cfg, 16'h0027);
        do_cmd(1'b0, 7'h02, 16'h0026, 1'b0, 16'h0000);
        chk_state(1'b0, 1'b0, 1'b0);
        $display("test second power-up done");
        @(negedge i_clk_sys);
        check("wr_count", n_wr[15:0], 16'd4);
        check("crc_err", crc_err, 1'b0);
        check("frame_err", n_ferr[15:0], 16'd0);
        check("rsp_left", 16'(exp_q.size()), 16'd0);
        summarize();
    end
endmodule : test_serial_config_init

`default_nettype wire
